/* crc_pkg.sv */
// Purpose: Shared constants, types and arithmetic of the CRC generator
// Assumes: 32-bit APB register words, byte offsets below
// Notes: Register fields sit in the low 16 bits of each word
package crc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_POLY_TERMS_LOW = 8'h08;
    localparam logic [7:0] OFS_POLY_TERMS_HIGH = 8'h0C;
    localparam logic [7:0] OFS_DATA_IN_LOW = 8'h10;
    localparam logic [7:0] OFS_DATA_IN_HIGH = 8'h14;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h18;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h1C;

    // Field positions in control_one
    localparam int EN_BIT = 15;
    localparam int VWORD_LSB = 8;
    localparam int FULL_BIT = 7;
    localparam int EMPTY_BIT = 6;
    localparam int ISEL_BIT = 5;
    localparam int GO_BIT = 4;
    localparam int LSB_FIRST_BIT = 3;
    localparam int CALC_BUSY_BIT = 0;
    // Field positions in control_two
    localparam int DW_LSB = 8;
    localparam int PLEN_LSB = 0;
    localparam int FIELD_W = 5;

    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int FIFO_AW = 4;
    localparam int FIFO_WORDS = 16;

    // FIFO depth per width band
    localparam logic [4:0] DEPTH_WIDE = 5'h04;
    localparam logic [4:0] DEPTH_MID = 5'h08;
    localparam logic [4:0] DEPTH_NARROW = 5'h10;
    localparam logic [4:0] DW_WIDE_MIN = 5'h10;
    localparam logic [4:0] DW_MID_MIN = 5'h08;

    localparam logic [5:0] BITS_PER_CYCLE = 6'h02;
    localparam logic [4:0] CNT_ONE = 5'h01;

    typedef struct packed {
        logic [31:0] poly;
        logic [4:0] plen;
        logic [4:0] dw;
        logic lsb_first;
    } crc_cfg_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_SHIFT = 2'b10
    } eng_state_t;

    // Ones in bits f..0
    function automatic logic [31:0] mask_bits(input logic [4:0] f);
        logic [32:0] m;
        m = (33'h0_0000_0002 << f) - 33'h0_0000_0001;
        return m[31:0];
    endfunction

    // One serial step; the top term is the feedback tap itself
    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                             input logic [31:0] poly, input logic [4:0] plen);
        logic [31:0] nxt;
        nxt = {crc[30:0], 1'b0};
        if (crc[plen] ^ din) begin
            nxt = nxt ^ poly;
        end
        return nxt & mask_bits(plen);
    endfunction

    function automatic logic [4:0] fifo_depth(input logic [4:0] dw);
        logic [4:0] d;
        d = DEPTH_NARROW;
        if (dw >= DW_WIDE_MIN) begin
            d = DEPTH_WIDE;
        end else if (dw >= DW_MID_MIN) begin
            d = DEPTH_MID;
        end
        return d;
    endfunction

    // (field + 1) / 2
    function automatic logic [4:0] half_len(input logic [4:0] f);
        logic [5:0] s;
        s = {1'b0, f} + 6'h01;
        return s[5:1];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

endpackage

/* crc_fifo_mem.sv */
// Purpose: Word store of the data FIFO, registered read port
// Assumes: Pointers and count are kept by the owner
// Notes: Array itself has no reset
`timescale 1ns/100ps
module crc_fifo_mem (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Write port
    input wire logic wr_en,
    input wire logic [crc_pkg::FIFO_AW-1:0] wr_addr,
    input wire logic [crc_pkg::WORD_W-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [crc_pkg::FIFO_AW-1:0] rd_addr,
    output logic [crc_pkg::WORD_W-1:0] rd_data
);
    logic [crc_pkg::WORD_W-1:0] mem_q [crc_pkg::FIFO_WORDS];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

/* crc_shift_engine.sv */
// Purpose: Shift buffer and CRC shift engine, two bits per cycle
// Assumes: Loaded word is already masked to the data width
// Notes: Seed writes take priority over shifting
`timescale 1ns/100ps
module crc_shift_engine (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    // Configuration
    input wire crc_pkg::crc_cfg_t cfg,
    // Word from the FIFO
    input wire logic load,
    input wire logic [crc_pkg::WORD_W-1:0] load_word,
    // Seed writes
    input wire logic seed_wr_lo,
    input wire logic seed_wr_hi,
    input wire logic [crc_pkg::HALF_W-1:0] seed_data,
    // Status and result
    output logic idle,
    output logic [crc_pkg::WORD_W-1:0] crc_value
);
    crc_pkg::eng_state_t state_q;
    logic [crc_pkg::WORD_W-1:0] buf_q;
    logic [5:0] rem_q;
    logic [31:0] crc_q;
    logic [5:0] r1;
    logic [5:0] r2;
    logic b1;
    logic b2;
    logic [31:0] step1;
    logic [31:0] step2;

    // Msb-first picks from the top of the remaining bits, lsb-first from bit 0
    always_comb begin
        r1 = rem_q - 6'h01;
        r2 = rem_q - crc_pkg::BITS_PER_CYCLE;
        b1 = cfg.lsb_first ? buf_q[0] : buf_q[r1[4:0]];
        b2 = cfg.lsb_first ? buf_q[1] : buf_q[r2[4:0]];
        step1 = crc_pkg::crc_step(crc_q, b1, cfg.poly, cfg.plen);
        step2 = (rem_q >= crc_pkg::BITS_PER_CYCLE) ?
                crc_pkg::crc_step(step1, b2, cfg.poly, cfg.plen) : step1;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            state_q <= crc_pkg::ENG_IDLE;
            buf_q <= '0;
            rem_q <= '0;
        end else if (load) begin
            state_q <= crc_pkg::ENG_SHIFT;
            buf_q <= load_word;
            rem_q <= {1'b0, cfg.dw} + 6'h01;
        end else begin
            case (state_q)
                crc_pkg::ENG_SHIFT: begin
                    if (rem_q <= crc_pkg::BITS_PER_CYCLE) begin
                        rem_q <= '0;
                        state_q <= crc_pkg::ENG_IDLE;
                    end else begin
                        rem_q <= rem_q - crc_pkg::BITS_PER_CYCLE;
                    end
                    if (cfg.lsb_first) begin
                        buf_q <= buf_q >> crc_pkg::BITS_PER_CYCLE;
                    end
                end
                default: begin
                    state_q <= crc_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Result register doubles as the seed register
    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            crc_q <= '0;
        end else if (seed_wr_lo) begin
            crc_q[15:0] <= seed_data;
        end else if (seed_wr_hi) begin
            crc_q[31:16] <= seed_data;
        end else if (state_q == crc_pkg::ENG_SHIFT) begin
            crc_q <= step2;
        end
    end

    assign idle = (state_q == crc_pkg::ENG_IDLE);
    assign crc_value = crc_q;

    default clocking ecb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || clear);

    a_shift_two_bits: assert property (
        (state_q == crc_pkg::ENG_SHIFT) && !load && (rem_q > 6'h02) |=> rem_q == $past(rem_q) - 6'h02)
        else $error("engine did not consume two bits");
    a_load_width: assert property (
        load |=> (rem_q == {1'b0, $past(cfg.dw)} + 6'h01) && (state_q == crc_pkg::ENG_SHIFT))
        else $error("loaded bit count differs from width");
endmodule

/* programmable_crc_generator.sv */
// Purpose: Programmable CRC generator with APB registers and data FIFO
// Assumes: APB slave, pready always high, no wait states
// Notes: crc_irq is a one-cycle pulse
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
module programmable_crc_generator (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event output
    output logic crc_irq
);
    logic en_q;
    logic isel_q;
    logic go_q;
    logic lsb_q;
    logic [4:0] dw_q;
    logic [4:0] plen_q;
    logic [31:1] terms_q;
    logic [31:0] hold_q;
    logic [31:0] hold_d;
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic [3:0] wptr_q;
    logic [3:0] rptr_q;
    logic pop_pend_q;
    logic worked_q;
    logic irq_q;
    logic [4:0] fin_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic [31:0] mem_rd;
    logic [31:0] crc_value;
    logic eng_idle;
    crc_pkg::crc_cfg_t cfg;
    logic wr_acc;
    logic wr_c1;
    logic wr_c2;
    logic wr_pl;
    logic wr_ph;
    logic wr_dl;
    logic wr_dh;
    logic wr_rl;
    logic wr_rh;
    logic [15:0] c1_new;
    logic [15:0] c2_new;
    logic [15:0] terms_lo_new;
    logic [4:0] depth;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic done_evt;
    logic irq_evt;
    logic [31:0] rd_val;
    logic rd_hit;

    assign wr_acc = psel && penable && pwrite;
    assign wr_c1 = wr_acc && (paddr == crc_pkg::OFS_CONTROL_ONE);
    assign wr_c2 = wr_acc && (paddr == crc_pkg::OFS_CONTROL_TWO);
    assign wr_pl = wr_acc && (paddr == crc_pkg::OFS_POLY_TERMS_LOW);
    assign wr_ph = wr_acc && (paddr == crc_pkg::OFS_POLY_TERMS_HIGH);
    assign wr_dl = wr_acc && (paddr == crc_pkg::OFS_DATA_IN_LOW);
    assign wr_dh = wr_acc && (paddr == crc_pkg::OFS_DATA_IN_HIGH);
    assign wr_rl = wr_acc && (paddr == crc_pkg::OFS_RESULT_LOW) && en_q;
    assign wr_rh = wr_acc && (paddr == crc_pkg::OFS_RESULT_HIGH) && en_q;

    assign c1_new = crc_pkg::merge16(16'h0000, pwdata[15:0], 2'h0) | crc_pkg::merge16(
        {en_q, 7'h00, isel_q ? 8'h20 : 8'h00} | {11'h000, go_q, lsb_q, 3'h0},
        pwdata[15:0], pstrb[1:0]);
    assign c2_new = crc_pkg::merge16({3'h0, dw_q, 3'h0, plen_q}, pwdata[15:0], pstrb[1:0]);
    assign terms_lo_new = crc_pkg::merge16({terms_q[15:1], 1'b0}, pwdata[15:0], pstrb[1:0]);

    // Control and configuration
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            en_q <= 1'b0;
            isel_q <= 1'b0;
            lsb_q <= 1'b0;
            dw_q <= '0;
            plen_q <= '0;
        end else begin
            if (wr_c1) begin
                en_q <= c1_new[crc_pkg::EN_BIT];
                isel_q <= c1_new[crc_pkg::ISEL_BIT];
                lsb_q <= c1_new[crc_pkg::LSB_FIRST_BIT];
            end
            if (wr_c2) begin
                dw_q <= c2_new[crc_pkg::DW_LSB +: crc_pkg::FIELD_W];
                plen_q <= c2_new[crc_pkg::PLEN_LSB +: crc_pkg::FIELD_W];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            terms_q <= '0;
        end else if (wr_pl) begin
            terms_q[15:1] <= terms_lo_new[15:1];
        end else if (wr_ph) begin
            terms_q[31:16] <= crc_pkg::merge16(terms_q[31:16], pwdata[15:0], pstrb[1:0]);
        end
    end

    // Bit 0 forced, the top term is the engine's own feedback tap
    assign cfg.poly = {terms_q, 1'b1};
    assign cfg.plen = plen_q;
    assign cfg.dw = dw_q;
    assign cfg.lsb_first = lsb_q;

    // Data input pair and FIFO fill
    always_comb begin
        hold_d = hold_q;
        if (wr_dl) begin
            hold_d[15:0] = crc_pkg::merge16(hold_q[15:0], pwdata[15:0], pstrb[1:0]);
        end
        if (wr_dh) begin
            hold_d[31:16] = crc_pkg::merge16(hold_q[31:16], pwdata[15:0], pstrb[1:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hold_q <= '0;
        end else if (!en_q) begin
            hold_q <= {16'h0000, hold_q[15:0]};
        end else begin
            hold_q <= hold_d;
        end
    end

    // Top bit of width lives in the low word below 16, its byte lane is dw[3]
    assign push = en_q && !full && pstrb[dw_q[3]] &&
                  ((wr_dl && !dw_q[4]) || (wr_dh && dw_q[4]));
    assign depth = crc_pkg::fifo_depth(dw_q);
    assign full = (count_q == depth);
    assign empty = (count_q == 5'h00);
    assign pop = en_q && go_q && !empty && eng_idle && !pop_pend_q;
    assign done_evt = en_q && go_q && worked_q && empty && eng_idle && !pop_pend_q;

    always_comb begin
        count_d = count_q;
        if (!en_q) begin
            count_d = '0;
        end else if (push && !pop) begin
            count_d = count_q + crc_pkg::CNT_ONE;
        end else if (pop && !push) begin
            count_d = count_q - crc_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_q <= '0;
            wptr_q <= '0;
            rptr_q <= '0;
            pop_pend_q <= 1'b0;
        end else if (!en_q) begin
            count_q <= '0;
            wptr_q <= '0;
            rptr_q <= '0;
            pop_pend_q <= 1'b0;
        end else begin
            count_q <= count_d;
            pop_pend_q <= pop;
            if (push) begin
                wptr_q <= wptr_q + 4'h1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 4'h1;
            end
        end
    end

    crc_fifo_mem u_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_en(push),
        .wr_addr(wptr_q),
        .wr_data(hold_d & crc_pkg::mask_bits(dw_q)),
        .rd_en(pop),
        .rd_addr(rptr_q),
        .rd_data(mem_rd)
    );

    crc_shift_engine u_engine (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(!en_q),
        .cfg(cfg),
        .load(pop_pend_q),
        .load_word(mem_rd),
        .seed_wr_lo(wr_rl),
        .seed_wr_hi(wr_rh),
        .seed_data(pwdata[15:0]),
        .idle(eng_idle),
        .crc_value(crc_value)
    );

    // Software write of go wins over the hardware clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            go_q <= 1'b0;
            worked_q <= 1'b0;
        end else begin
            if (wr_c1) begin
                go_q <= c1_new[crc_pkg::GO_BIT];
            end else if (done_evt && isel_q) begin
                // Count mode keeps go, so a trailing dummy word still shifts
                go_q <= 1'b0;
            end
            if (pop) begin
                worked_q <= 1'b1;
            end else if (done_evt || (wr_c1 && !c1_new[crc_pkg::GO_BIT]) || !en_q) begin
                worked_q <= 1'b0;
            end
        end
    end

    assign irq_evt = isel_q ? (done_evt && !wr_c1)
                            : (count_q == crc_pkg::CNT_ONE && count_d == 5'h00);

    // Tail of the calculation still running after the event
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
            fin_q <= '0;
        end else begin
            irq_q <= irq_evt;
            if (irq_evt) begin
                fin_q <= crc_pkg::half_len(plen_q);
            end else if (fin_q != 5'h00) begin
                fin_q <= fin_q - crc_pkg::CNT_ONE;
            end
        end
    end
    assign crc_irq = irq_q;

    // Read decode
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        if (paddr == crc_pkg::OFS_CONTROL_ONE) begin
            rd_val[crc_pkg::EN_BIT] = en_q;
            rd_val[crc_pkg::VWORD_LSB +: crc_pkg::FIELD_W] = count_q;
            rd_val[crc_pkg::FULL_BIT] = full;
            rd_val[crc_pkg::EMPTY_BIT] = empty;
            rd_val[crc_pkg::ISEL_BIT] = isel_q;
            rd_val[crc_pkg::GO_BIT] = go_q;
            rd_val[crc_pkg::LSB_FIRST_BIT] = lsb_q;
            rd_val[crc_pkg::CALC_BUSY_BIT] = (fin_q != 5'h00);
        end else if (paddr == crc_pkg::OFS_CONTROL_TWO) begin
            rd_val[crc_pkg::DW_LSB +: crc_pkg::FIELD_W] = dw_q;
            rd_val[crc_pkg::PLEN_LSB +: crc_pkg::FIELD_W] = plen_q;
        end else if (paddr == crc_pkg::OFS_POLY_TERMS_LOW) begin
            rd_val[15:0] = {terms_q[15:1], 1'b0};
        end else if (paddr == crc_pkg::OFS_POLY_TERMS_HIGH) begin
            rd_val[15:0] = terms_q[31:16];
        end else if (paddr == crc_pkg::OFS_DATA_IN_LOW) begin
            rd_val[15:0] = hold_q[15:0];
        end else if (paddr == crc_pkg::OFS_DATA_IN_HIGH) begin
            rd_val[15:0] = hold_q[31:16];
        end else if (paddr == crc_pkg::OFS_RESULT_LOW) begin
            rd_val[15:0] = crc_value[15:0];
        end else if (paddr == crc_pkg::OFS_RESULT_HIGH) begin
            rd_val[15:0] = crc_value[31:16];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Captured in the setup cycle, so the access phase always takes one cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            slverr_q <= !rd_hit;
        end
    end
    assign prdata = prdata_q;
    assign pslverr = slverr_q && psel && penable;
    assign pready = 1'b1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_disabled_count: assert property (!en_q |=> count_q == 5'h00 && empty)
        else $error("count not cleared while disabled");
    a_push_increments: assert property (
        push && !pop && en_q |=> count_q == $past(count_q) + 5'h01)
        else $error("count did not rise on top-bit write");
    a_no_push_full: assert property (full |-> !push)
        else $error("word accepted while full");
    a_pop_needs_go: assert property (pop |-> go_q && count_q != 5'h00 && eng_idle)
        else $error("shifting started without go or data");
    a_pop_decrements: assert property (
        pop && !push |=> (count_q == $past(count_q) - 5'h01) && pop_pend_q ##1 !eng_idle)
        else $error("pop did not move a word to the buffer");
    a_count_irq: assert property (
        en_q && !isel_q && count_q == 5'h01 && pop && !push |=> crc_irq)
        else $error("no interrupt on count one to zero");
    a_swclear_quiet: assert property (
        isel_q && wr_c1 && !c1_new[crc_pkg::GO_BIT] |=> !crc_irq)
        else $error("software go clear raised interrupt");
    a_done_clears_go: assert property (
        done_evt && !wr_c1 && isel_q |=> !go_q && crc_irq)
        else $error("hardware finish did not clear go");
    a_tail_count: assert property (
        crc_irq && $stable(plen_q) |-> fin_q == crc_pkg::half_len(plen_q))
        else $error("calculation tail count wrong");
    a_full_depth: assert property (
        en_q && push && !pop && (count_q + 5'h01 == depth) && !wr_c2 |=> full)
        else $error("full not set at configured depth");

    c_fifo_full: cover property (en_q && full);
    c_count_irq: cover property (!isel_q && crc_irq);
    c_done_irq: cover property (isel_q && crc_irq);
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench of the programmable CRC generator over APB
// Assumes: Settled read data and pslverr in the access cycle, pready high
// Notes: Expected reads queue up in the driver; a watcher pops and compares
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h3;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crc_irq;
    logic [32:0] expq[$];
    int miscompares = 0;
    int checked = 0;
    int irqs = 0;
    int seed = 32'h55B2;

    programmable_crc_generator u_programmable_crc_generator (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .crc_irq(crc_irq));

    always #25 ref_clk = ~ref_clk;

    task automatic chk(input logic [32:0] exp, input logic [32:0] act);
        checked++;
        if (act !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic conclude();
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        expq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    always @(posedge ref_clk) begin
        if (crc_irq === 1'b1) irqs++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() > 0) chk(expq.pop_front(), {pslverr, prdata});
        end
    end

    // Own serial model: 16-bit polynomial 0x1021, bit 0 always fed back
    function automatic logic [15:0] model(input logic [15:0] c, input logic [7:0] d,
                                          input logic lsb);
        logic b;
        for (int i = 0; i < 8; i++) begin
            b = lsb ? d[i] : d[7-i];
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction

    task automatic run_crc(input logic lsb, input logic isel);
        logic [15:0] crc;
        logic [31:0] c1;
        logic [31:0] d;
        int n;
        crc = 16'hFFFF;
        c1 = 32'h8000 | (32'(isel) << 5) | (32'(lsb) << 3);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, c1);
        apb(1'b1, crc_pkg::OFS_RESULT_LOW, 32'h0000FFFF);
        apb(1'b1, crc_pkg::OFS_RESULT_HIGH, 32'h0);
        // Three data bytes, then zero bytes as long as the polynomial
        for (int i = 0; i < 5; i++) begin
            d = $random(seed);
            if (i >= 3) d = 32'h0;
            apb(1'b1, crc_pkg::OFS_DATA_IN_LOW, {16'h0, d[15:0]});
            crc = model(crc, d[7:0], lsb);
        end
        rd(crc_pkg::OFS_CONTROL_ONE, {1'b0, c1 | 32'h0500});
        n = irqs;
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, c1 | 32'h0010);
        for (int i = 0; i < 200 && irqs == n; i++) @(posedge ref_clk);
        // Length and width halves plus the buffer move
        repeat (16) @(posedge ref_clk);
        chk(33'(irqs - n), 33'h1);
        rd(crc_pkg::OFS_RESULT_LOW, {17'h0, crc});
        rd(crc_pkg::OFS_CONTROL_ONE, {1'b0, c1 | 32'h0040 | (32'(!isel) << 4)});
    endtask

    // Width above length: finish the word, then one dummy word at the length
    task automatic run_wide();
        logic [15:0] crc;
        logic [31:0] d;
        crc = 16'hFFFF;
        d = $random(seed);
        apb(1'b1, crc_pkg::OFS_CONTROL_TWO, 32'h1F0F);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h8010);
        apb(1'b1, crc_pkg::OFS_RESULT_LOW, 32'h0000FFFF);
        apb(1'b1, crc_pkg::OFS_RESULT_HIGH, 32'h0);
        apb(1'b1, crc_pkg::OFS_DATA_IN_LOW, {16'h0, d[15:0]});
        apb(1'b1, crc_pkg::OFS_DATA_IN_HIGH, {16'h0, d[31:16]});
        for (int i = 3; i >= 0; i--) crc = model(crc, d[i*8 +: 8], 1'b0);
        repeat (16) @(posedge ref_clk);
        apb(1'b1, crc_pkg::OFS_CONTROL_TWO, 32'h0F0F);
        apb(1'b1, crc_pkg::OFS_DATA_IN_LOW, 32'h0);
        crc = model(model(crc, 8'h00, 1'b0), 8'h00, 1'b0);
        repeat (10) @(posedge ref_clk);
        rd(crc_pkg::OFS_RESULT_LOW, {17'h0, crc});
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(crc_pkg::OFS_CONTROL_ONE, 33'h0_0000_0040);
        rd(8'h20, 33'h1_0000_0000);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h8000);
        apb(1'b1, crc_pkg::OFS_CONTROL_TWO, 32'h1F0F);
        rd(crc_pkg::OFS_CONTROL_TWO, 33'h0_0000_1F0F);
        // Fifth word arrives while full and must be dropped
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, crc_pkg::OFS_DATA_IN_LOW, 32'($random(seed)));
            apb(1'b1, crc_pkg::OFS_DATA_IN_HIGH, 32'($random(seed)));
        end
        rd(crc_pkg::OFS_CONTROL_ONE, 33'h0_0000_8480);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h0);
        rd(crc_pkg::OFS_CONTROL_ONE, 33'h0_0000_0040);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h8000);
        apb(1'b1, crc_pkg::OFS_CONTROL_TWO, 32'h070F);
        apb(1'b1, crc_pkg::OFS_POLY_TERMS_LOW, 32'h1020);
        apb(1'b1, crc_pkg::OFS_POLY_TERMS_HIGH, 32'h0);
        run_crc(1'b0, 1'b0);
        run_crc(1'b1, 1'b1);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h8030);
        apb(1'b1, crc_pkg::OFS_CONTROL_ONE, 32'h8020);
        repeat (4) @(posedge ref_clk);
        chk(33'(irqs), 33'h2);
        run_wide();
        chk(33'(irqs), 33'h4);
        conclude();
    end
endmodule
